// ### design/sto_regs.vh
// Register map, field positions, characters and timing constants of the serial time string output.
`ifndef STO_REGS_VH
`define STO_REGS_VH

// Register byte offsets on the APB bus.
`define STO_ADDR_CTRL 8'h00
`define STO_ADDR_TIME 8'h04
`define STO_ADDR_LIMIT 8'h08
`define STO_ADDR_STATUS 8'h0C

// Control register fields.
`define STO_CTRL_AUTO 0
`define STO_CTRL_PAR_LO 1
`define STO_CTRL_PAR_HI 2
`define STO_CTRL_FLY_LO 3
`define STO_CTRL_FLY_HI 4
`define STO_CTRL_FREE 5
`define STO_CTRL_RESET 6'h01

// Parity selections.
`define STO_PAR_ODD 2'h0
`define STO_PAR_NONE 2'h1
`define STO_PAR_EVEN 2'h2

// Flywheel character selections.
`define STO_FLY_SPACE 2'h0
`define STO_FLY_X 2'h1
`define STO_FLY_F 2'h2

// Reset values of the other writable registers.
`define STO_TIME_RESET 24'h00_0000
`define STO_LIMIT_RESET 32'hFFFF_FFFF

// Characters on the line.
`define STO_CHAR_SPACE 8'h20
`define STO_CHAR_X 8'h58
`define STO_CHAR_F 8'h46
`define STO_CHAR_DIGIT0 8'h30
`define STO_CMD_START_UC 8'h43
`define STO_CMD_START_LC 8'h63
`define STO_CMD_STOP_UC 8'h52
`define STO_CMD_STOP_LC 8'h72

// String length: six time digits, then the quality character.
`define STO_STR_LAST 3'h6

// Line timing.
`define STO_CLK_HZ 100000000
`define STO_BAUD 9600

`endif

// ### design/sto_top.v
// Serial time string output: APB registers, quality character state machine, command receiver and transmitter.
//
// The APB interface to the registers and the address map are this design's own decisions.
`include "sto_regs.vh"

// Overview of operation
// - Send one time string each second while active
// - Autostart sends without commands, ignores C/R
// - Without autostart, C starts and R stops
// - Parity odd, none or even, both ends alike
// - Quality character ends every time string
// - Send X until first reference lock
// - Reference lock makes quality character a space
// - Holdover keeps the space
// - Holdover expiry sends configured flywheel character
// - Reference return restores the space
// - Flywheel character is space, X or F
// - Forced free run freezes the quality state
// - Quality change may lag by a string
// - Holdover expires when error reaches limit
module sto_top #(
    parameter BIT_CYCLES = `STO_CLK_HZ / `STO_BAUD
) (
    // Clock and reset.
    input wire CORE_CLK,
    input wire NRST,
    // APB slave.
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Hardware clock status, same clock domain.
    input wire TOP_OF_SECOND,
    input wire REF_LOCKED,
    input wire [31:0] TIME_ERROR_EST,
    // Serial line.
    input wire RXD,
    output reg TXD
);

    // Quality character states.
    localparam Q_INVALID = 2'h0;
    localparam Q_VALID = 2'h1;
    localparam Q_HOLD = 2'h2;
    localparam Q_EXPIRED = 2'h3;

    // Software registers.
    reg [5:0] ctrl_reg;
    reg [23:0] time_reg;
    reg [31:0] limit_reg;
    // Quality state and output activity.
    reg [1:0] qual_reg;
    reg active_reg;
    // Receiver state.
    reg rxd_meta_reg;
    reg rxd_sync_reg;
    reg rx_busy_reg;
    reg [15:0] rx_div_reg;
    reg [3:0] rx_cnt_reg;
    reg [10:0] rx_shift_reg;
    // Transmitter state.
    reg sending_reg;
    reg [2:0] str_idx_reg;
    reg [10:0] tx_frame_reg;
    reg [3:0] tx_left_reg;
    reg [15:0] tx_div_reg;
    reg [23:0] time_latch_reg;
    reg [7:0] qual_char_reg;

    // Decoded control fields.
    wire autostart = ctrl_reg[`STO_CTRL_AUTO];
    wire [1:0] par_mode = ctrl_reg[`STO_CTRL_PAR_HI:`STO_CTRL_PAR_LO];
    wire [1:0] fly_sel = ctrl_reg[`STO_CTRL_FLY_HI:`STO_CTRL_FLY_LO];
    wire force_free = ctrl_reg[`STO_CTRL_FREE];
    // Frame length in bits: start, eight data, optional parity, stop.
    wire [3:0] frame_bits = (par_mode == `STO_PAR_NONE) ? 4'hA : 4'hB;

    // Parity bit for a character; the receiver uses the same function.
    function par_bit;
        input [7:0] data;
        input [1:0] mode;
        begin
            par_bit = (mode == `STO_PAR_EVEN) ? (^data) : ~(^data);
        end
    endfunction

    // Builds a frame, LSB first; without parity the stop bit moves down one place.
    function [10:0] build_frame;
        input [7:0] data;
        input [1:0] mode;
        begin
            if (mode == `STO_PAR_NONE) begin
                build_frame = {2'b11, data, 1'b0};
            end else begin
                build_frame = {1'b1, par_bit(data, mode), data, 1'b0};
            end
        end
    endfunction

    // Quality character for a state; unknown flywheel codes fall back to space.
    function [7:0] qual_char;
        input [1:0] state;
        input [1:0] sel;
        begin
            if (state == Q_INVALID) begin
                qual_char = `STO_CHAR_X;
            end else if (state != Q_EXPIRED) begin
                qual_char = `STO_CHAR_SPACE;
            end else if (sel == `STO_FLY_X) begin
                qual_char = `STO_CHAR_X;
            end else if (sel == `STO_FLY_F) begin
                qual_char = `STO_CHAR_F;
            end else begin
                qual_char = `STO_CHAR_SPACE;
            end
        end
    endfunction

    // Character at a string position: six BCD digits, most significant first, then quality.
    function [7:0] str_char;
        input [2:0] idx;
        input [23:0] tod;
        input [7:0] qchar;
        reg [3:0] nib;
        begin
            nib = tod[23:20];
            case (idx)
                3'h1: nib = tod[19:16];
                3'h2: nib = tod[15:12];
                3'h3: nib = tod[11:8];
                3'h4: nib = tod[7:4];
                3'h5: nib = tod[3:0];
                default: nib = tod[23:20];
            endcase
            str_char = (idx == `STO_STR_LAST) ? qchar : (`STO_CHAR_DIGIT0 | {4'h0, nib});
        end
    endfunction

    // APB decode; the slave always answers in the first access cycle.
    wire apb_setup = PSEL & ~PENABLE;
    wire apb_access = PSEL & PENABLE;
    wire addr_ctrl = (PADDR == `STO_ADDR_CTRL);
    wire addr_time = (PADDR == `STO_ADDR_TIME);
    wire addr_limit = (PADDR == `STO_ADDR_LIMIT);
    wire addr_status = (PADDR == `STO_ADDR_STATUS);
    wire addr_ok = addr_ctrl | addr_time | addr_limit | addr_status;
    wire apb_wr = apb_access & PWRITE & addr_ok;
    assign PREADY = 1'b1;
    // Unmapped addresses and writes to the read-only status word report an error.
    assign PSLVERR = apb_access & (~addr_ok | (PWRITE & addr_status));

    // Register writes take effect on the access edge only.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= `STO_CTRL_RESET;
            time_reg <= `STO_TIME_RESET;
            limit_reg <= `STO_LIMIT_RESET;
        end else if (apb_wr) begin
            if (addr_ctrl) begin
                ctrl_reg <= PWDATA[5:0];
            end else if (addr_time) begin
                time_reg <= PWDATA[23:0];
            end else if (addr_limit) begin
                limit_reg <= PWDATA;
            end
        end
    end

    // Read data is prepared in the setup cycle so that it comes from a flip-flop.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (apb_setup) begin
            if (addr_ctrl) begin
                PRDATA <= {26'h000_0000, ctrl_reg};
            end else if (addr_time) begin
                PRDATA <= {8'h00, time_reg};
            end else if (addr_limit) begin
                PRDATA <= limit_reg;
            end else if (addr_status) begin
                PRDATA <= {20'h0_0000, qual_char_reg, sending_reg, qual_reg, active_reg};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // Holdover ends when the estimated error reaches the limit.
    wire err_over = (TIME_ERROR_EST >= limit_reg);

    // Quality state machine; a forced free run freezes whatever state holds now.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            qual_reg <= Q_INVALID;
        end else if (!force_free) begin
            case (qual_reg)
                Q_INVALID: begin
                    if (REF_LOCKED) begin
                        qual_reg <= Q_VALID;
                    end
                end
                Q_VALID: begin
                    if (!REF_LOCKED) begin
                        qual_reg <= Q_HOLD;
                    end
                end
                Q_HOLD: begin
                    if (REF_LOCKED) begin
                        qual_reg <= Q_VALID;
                    end else if (err_over) begin
                        qual_reg <= Q_EXPIRED;
                    end
                end
                default: begin
                    if (REF_LOCKED) begin
                        qual_reg <= Q_VALID;
                    end
                end
            endcase
        end
    end

    // Two flip-flops bring the line into the clock domain before anything looks at it.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= RXD;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // Receiver samples each bit in its middle; the first sample is half a bit after the start edge.
    wire rx_tick = rx_busy_reg & (rx_div_reg == 16'h0000);
    wire rx_done = rx_tick & (rx_cnt_reg == frame_bits - 4'h1);
    wire [10:0] rx_word = {rxd_sync_reg, rx_shift_reg[10:1]};
    // Without parity the ten bits sit in the top of the shift register.
    wire [7:0] rx_data = (par_mode == `STO_PAR_NONE) ? rx_word[9:2] : rx_word[8:1];
    wire rx_par_ok = (par_mode == `STO_PAR_NONE) | (rx_word[9] == par_bit(rx_data, par_mode));
    wire rx_good = rx_done & rxd_sync_reg & rx_par_ok;
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_busy_reg <= 1'b0;
            rx_div_reg <= 16'h0000;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 11'h7FF;
        end else if (!rx_busy_reg) begin
            if (!rxd_sync_reg) begin
                rx_busy_reg <= 1'b1;
                rx_div_reg <= BIT_CYCLES[16:1] - 16'h0001;
                rx_cnt_reg <= 4'h0;
            end
        end else if (rx_tick) begin
            rx_shift_reg <= rx_word;
            rx_div_reg <= BIT_CYCLES[15:0] - 16'h0001;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            // A start bit that is high again was a glitch; the frame ends at its stop bit.
            if (((rx_cnt_reg == 4'h0) && rxd_sync_reg) || rx_done) begin
                rx_busy_reg <= 1'b0;
            end
        end else begin
            rx_div_reg <= rx_div_reg - 16'h0001;
        end
    end

    // Start and stop commands only act without autostart; autostart keeps output on.
    wire cmd_start = rx_good & ((rx_data == `STO_CMD_START_UC) | (rx_data == `STO_CMD_START_LC));
    wire cmd_stop = rx_good & ((rx_data == `STO_CMD_STOP_UC) | (rx_data == `STO_CMD_STOP_LC));
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            active_reg <= 1'b0;
        end else if (autostart) begin
            active_reg <= 1'b1;
        end else if (cmd_start) begin
            active_reg <= 1'b1;
        end else if (cmd_stop) begin
            active_reg <= 1'b0;
        end
    end

    // A string starts at the top of a second; a second that arrives mid-string is skipped.
    wire str_start = TOP_OF_SECOND & active_reg & ~sending_reg;
    wire tx_tick = sending_reg & (tx_div_reg == 16'h0000);
    wire tx_char_end = tx_tick & (tx_left_reg == 4'h1);
    wire str_end = tx_char_end & (str_idx_reg == `STO_STR_LAST);
    wire [10:0] next_frame = build_frame(str_char(str_idx_reg + 3'h1, time_latch_reg, qual_char_reg), par_mode);

    // Time and quality are latched at string start, so a state change shows in the next string.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            time_latch_reg <= `STO_TIME_RESET;
            qual_char_reg <= `STO_CHAR_X;
        end else if (str_start) begin
            time_latch_reg <= time_reg;
            qual_char_reg <= qual_char(qual_reg, fly_sel);
        end
    end

    // Transmitter walks the seven characters of a string back to back.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sending_reg <= 1'b0;
            str_idx_reg <= 3'h0;
            tx_frame_reg <= 11'h7FF;
            tx_left_reg <= 4'h0;
            tx_div_reg <= 16'h0000;
            TXD <= 1'b1;
        end else if (str_start) begin
            sending_reg <= 1'b1;
            str_idx_reg <= 3'h0;
            tx_frame_reg <= build_frame(str_char(3'h0, time_reg, `STO_CHAR_SPACE), par_mode);
            tx_left_reg <= frame_bits + 4'h1; // The first character also counts its start bit.
            tx_div_reg <= 16'h0000;
        end else if (tx_tick) begin
            tx_div_reg <= BIT_CYCLES[15:0] - 16'h0001;
            if (str_end) begin
                sending_reg <= 1'b0;
                TXD <= 1'b1;
            end else if (tx_char_end) begin
                // This character's stop bit has run its full time; the next start bit goes out now.
                str_idx_reg <= str_idx_reg + 3'h1;
                tx_frame_reg <= {1'b1, next_frame[10:1]};
                tx_left_reg <= frame_bits;
                TXD <= 1'b0;
            end else begin
                TXD <= tx_frame_reg[0];
                tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                tx_left_reg <= tx_left_reg - 4'h1;
            end
        end else if (sending_reg) begin
            tx_div_reg <= tx_div_reg - 16'h0001;
        end
    end

endmodule

// ### test/sto_line_model.sv
// Time receiver model: decodes strings from the line and sends command characters.
`include "sto_regs.vh"
module sto_line_model #(parameter int BIT_CYCLES = 16) (
    // Clock and line.
    input wire logic clk,
    input wire logic txd,
    input wire logic [1:0] par,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    int frame_errs = 0;
    // The receive line idles high, as a pulled-up serial line does.
    initial rxd = 1'b1;
    // Sample mid-bit so that edge placement within a cycle does not matter.
    always begin : rx
        logic [7:0] d;
        @(posedge clk iff txd === 1'b0);
        repeat (BIT_CYCLES / 2 - 1) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            d[i] = txd;
        end
        if (par != `STO_PAR_NONE) begin
            repeat (BIT_CYCLES) @(posedge clk);
            if (txd !== ((par == `STO_PAR_EVEN) ? ^d : ~^d)) frame_errs++;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        if (txd !== 1'b1) frame_errs++;
        rx_q.push_back(d);
    end
    // Send one command with the parity that the line is set to.
    task automatic send(input logic [7:0] c);
        logic [10:0] f;
        f = {1'b1, (par == `STO_PAR_EVEN) ? ^c : ~^c, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || par != `STO_PAR_NONE) begin
                rxd <= f[i];
                repeat (BIT_CYCLES) @(posedge clk);
            end
        end
    endtask
endmodule

// ### test/sto_properties.sv
// Port checker of the serial time string output, bound into its top module.
`include "sto_regs.vh"
module sto_properties #(parameter BIT_CYCLES = 16) (
    // Clock and reset.
    input wire CORE_CLK,
    input wire NRST,
    // Bus.
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire PREADY,
    input wire PSLVERR,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    // Clock status and serial line.
    input wire [31:0] TIME_ERROR_EST,
    input wire TOP_OF_SECOND,
    input wire REF_LOCKED,
    input wire RXD,
    input wire TXD
);
    timeunit 1ns;
    timeprecision 1ps;
    int hi_run;
    int lo_run;
    logic auto_on;
    wire acc = PSEL && PENABLE;
    wire bad = (|PADDR[7:4]) || (|PADDR[1:0]);
    // A high run longer than any in-frame run means no string is in flight.
    wire idle = hi_run >= 12 * BIT_CYCLES;
    // Run lengths of the line, and the autostart bit as written over the bus.
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            hi_run <= 0;
            lo_run <= 0;
            auto_on <= 1'b1;
        end else begin
            hi_run <= TXD ? hi_run + (hi_run < 9999) : 0;
            lo_run <= TXD ? 0 : lo_run + 1;
            if (acc && PWRITE && PADDR == `STO_ADDR_CTRL) begin
                auto_on <= PWDATA[`STO_CTRL_AUTO];
            end
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    AST_NO_WAIT: assert property (acc |-> PREADY) else $error("wait state inserted");
    AST_ERR_BAD: assert property (acc && (bad || PWRITE && PADDR == `STO_ADDR_STATUS) |-> PSLVERR)
        else $error("bad access not refused");
    AST_ERR_OK: assert property (acc && !bad && !PWRITE |-> !PSLVERR) else $error("good read refused");
    AST_RD_ZERO: assert property (acc && bad && !PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_AUTO_START: assert property (auto_on && idle && TOP_OF_SECOND |=> ##1 !TXD)
        else $error("string did not start");
    AST_NO_START: assert property (idle && TXD && !TOP_OF_SECOND && !$past(TOP_OF_SECOND) |=> TXD)
        else $error("string started off the second");
    AST_START_HOLD: assert property ($fell(TXD) |-> !TXD [*8]) else $error("short low bit");
    AST_BIT_WIDTH: assert property ($rose(TXD) |-> lo_run % BIT_CYCLES == 0) else $error("bad bit width");
    COV_START: cover property (auto_on && idle && TOP_OF_SECOND);
    COV_ERR: cover property (acc && PSLVERR);
    COV_MANUAL: cover property (!auto_on && TOP_OF_SECOND);
endmodule
bind sto_top sto_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .TIME_ERROR_EST(TIME_ERROR_EST), .TOP_OF_SECOND(TOP_OF_SECOND), .REF_LOCKED(REF_LOCKED),
    .RXD(RXD), .TXD(TXD));

// ### test/tb_top.sv
// Bench: bus, quality states, commands and parity of the time string output.
`include "sto_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 16;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic TOP_OF_SECOND = 1'b0;
    logic REF_LOCKED = 1'b0;
    logic [31:0] TIME_ERROR_EST = 32'h0000_0000;
    logic [1:0] line_par = `STO_PAR_ODD;
    logic [31:0] rdat;
    logic rerr;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, RXD, TXD;
    int err_total = 0;
    int checks_done = 0;
    always #5 CORE_CLK = ~CORE_CLK;
    sto_top #(.BIT_CYCLES(BITC)) uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TOP_OF_SECOND(TOP_OF_SECOND), .REF_LOCKED(REF_LOCKED), .TIME_ERROR_EST(TIME_ERROR_EST), .RXD(RXD),
        .TXD(TXD));
    sto_line_model #(.BIT_CYCLES(BITC)) line (.clk(CORE_CLK), .txd(TXD), .par(line_par), .rxd(RXD));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus transfer; the first edge keeps a new setup off the previous release.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            end_of_test();
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // One second: pulse the top of second and collect what the line carried.
    task automatic tick(input logic want, output logic [7:0] q);
        int n;
        line.rx_q.delete();
        repeat (200) @(posedge CORE_CLK);
        TOP_OF_SECOND <= 1'b1;
        @(posedge CORE_CLK);
        TOP_OF_SECOND <= 1'b0;
        n = 0;
        while (line.rx_q.size() < 7 && n < 1500) begin
            @(posedge CORE_CLK);
            n++;
        end
        if (want && n >= 1500) begin
            err_total++;
            end_of_test();
        end
        q = line.rx_q.size() > 6 ? line.rx_q[6] : 8'h00;
        if (!want) begin
            check("chars", 32'(line.rx_q.size()), 32'h0000_0000);
        end else begin
            check("chars", 32'(line.rx_q.size()), 32'h0000_0007);
            for (int i = 0; i < 6 && i < line.rx_q.size(); i++) begin
                check("digit", 32'(line.rx_q[i]), 32'(8'h31 + i));
            end
        end
    endtask
    // Quality may lag one string, so the second string is judged.
    task automatic qual(input logic [7:0] e);
        logic [7:0] q;
        tick(1'b1, q);
        tick(1'b1, q);
        check("quality", 32'(q), 32'(e));
    endtask
    task automatic t_regs;
        apb(`STO_ADDR_CTRL, 1'b0, 32'h0000_0000);
        check("ctrl", rdat, 32'h0000_0001);
        apb(`STO_ADDR_LIMIT, 1'b0, 32'h0000_0000);
        check("limit", rdat, 32'hFFFF_FFFF);
        apb(8'h10, 1'b0, 32'h0000_0000);
        check("unmapped", rdat, 32'h0000_0000);
        apb(`STO_ADDR_STATUS, 1'b1, 32'h0000_0000);
        check("status write", 32'(rerr), 32'h0000_0001);
        apb(`STO_ADDR_TIME, 1'b1, 32'h0012_3456);
        $display("register test done");
    endtask
    task automatic t_auto;
        line.send(`STO_CMD_STOP_UC);
        line.send(`STO_CMD_STOP_LC);
        qual(`STO_CHAR_X);
        $display("autostart test done");
    endtask
    task automatic t_qual;
        logic [7:0] fly [3] = '{`STO_CHAR_SPACE, `STO_CHAR_X, `STO_CHAR_F};
        REF_LOCKED <= 1'b1;
        qual(`STO_CHAR_SPACE);
        apb(`STO_ADDR_LIMIT, 1'b1, 32'h0000_0064);
        TIME_ERROR_EST <= 32'h0000_0063;
        REF_LOCKED <= 1'b0;
        qual(`STO_CHAR_SPACE);
        TIME_ERROR_EST <= 32'h0000_0064;
        for (int f = 0; f < 3; f++) begin
            apb(`STO_ADDR_CTRL, 1'b1, 32'(f << 3) | 32'h0000_0001);
            qual(fly[f]);
        end
        REF_LOCKED <= 1'b1;
        qual(`STO_CHAR_SPACE);
        apb(`STO_ADDR_CTRL, 1'b1, 32'h0000_0029);
        REF_LOCKED <= 1'b0;
        qual(`STO_CHAR_SPACE);
        $display("quality test done");
    endtask
    task automatic t_cmd;
        logic [7:0] q;
        for (int p = 0; p < 3; p++) begin
            apb(`STO_ADDR_CTRL, 1'b1, 32'(p << 1));
            line_par <= 2'(p);
            @(posedge CORE_CLK);
            line.send(p[0] ? `STO_CMD_STOP_LC : `STO_CMD_STOP_UC);
            tick(1'b0, q);
            line.send(p[0] ? `STO_CMD_START_LC : `STO_CMD_START_UC);
            tick(1'b1, q);
        end
        check("parity", 32'(line.frame_errs), 32'h0000_0000);
        $display("command test done");
    endtask
    initial begin
        repeat (4) @(posedge CORE_CLK);
        NRST <= 1'b1;
        t_regs();
        t_auto();
        t_qual();
        t_cmd();
        end_of_test();
    end
endmodule
